// ===== include/plt_pkg.sv
package plt_pkg;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] IDX_TUNING_CONTROL  = 8'he5;
  localparam logic [7:0] IDX_APPLIED_ARRAY   = 8'hf9;
  localparam logic [7:0] IDX_APPLIED_DAC     = 8'hfa;
  localparam logic [7:0] IDX_APPLIED_PUMP    = 8'hfb;
  localparam logic [7:0] IDX_LOOP_BREAK      = 8'hfc;
  localparam logic [7:0] IDX_PUMP_SCALING    = 8'hfd;
  localparam logic [7:0] IDX_OSC_ARRAY_FORCE    = 8'hfe;
  localparam logic [7:0] IDX_PUMP_OVERRIDE   = 8'hff;
  localparam logic [7:0] IDX_SLOT_SELECT     = 8'h80;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int TC_START_BIT     = 7;
  localparam int TC_DUAL_BIT      = 6;
  localparam int TC_WAIT_BIT      = 5;
  localparam int TC_CURRENT_BIT   = 4;
  localparam int TC_COMPLETE_BIT  = 3;
  localparam int PO_TP1_BIT       = 7;
  localparam int PO_TP2_BIT       = 6;
  localparam int PO_FORCE_BIT     = 5;
  localparam int VO_PUMP_OFF_BIT  = 5;
  localparam int VO_FORCE_BIT     = 4;
  localparam int LB_BREAK_BIT     = 4;
  localparam int SS_SLOT_BIT      = 0;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [2:0] RST_ITER_START   = 3'h5;
  localparam logic [4:0] RST_PUMP_FORCED  = 5'h10;
  localparam logic [3:0] RST_ARRAY_FORCED = 4'h8;
  localparam logic [5:0] RST_PUMP_SCALING = 6'h25;
  localparam logic [3:0] RST_DAC_OPEN     = 4'h4;

  // ****************************************************************
  // timing, in reference-clock cycles
  // ****************************************************************
  localparam int TUNE_FULL_REF_CYCLES = 25650;
  localparam int TUNE_HALF_REF_CYCLES = 12825;
  localparam int TUNE_CNT_W           = 15;

  typedef enum logic [1:0] {
    PLT_IDLE = 2'b00,
    PLT_RUN  = 2'b01,
    PLT_DONE = 2'b11
  } plt_state_t;

  // results handed in by the analog tuning engine at the end of a run
  typedef struct packed {
    logic [3:0] array;
    logic [4:0] pump;
  } plt_tune_res_t;

  // controls driven to the analog PLL
  typedef struct packed {
    logic       tuning_run;
    logic       tuning_double_current;
    logic [2:0] tuning_iter_start;
    logic [3:0] osc_array_applied;
    logic [4:0] pump_current_applied;
    logic [3:0] dac_applied;
    logic       dac_forced;
    logic       pump_off;
    logic       loop_open;
    logic       loop_testpoint_one_sel;
    logic       loop_testpoint_two_sel;
    logic [5:0] pump_scaling_factor;
  } plt_ana_ctrl_t;

endpackage : plt_pkg

// ===== core/plt_sequencer.sv
`timescale 1ns/1ps
module plt_sequencer #(
  parameter int FULL_CYCLES = plt_pkg::TUNE_FULL_REF_CYCLES,
  parameter int HALF_CYCLES = plt_pkg::TUNE_HALF_REF_CYCLES
) (
  input  wire logic  sys_clk,
  input  wire logic  reset,
  input  wire logic  start,
  input  wire logic  full_wait,
  input  wire logic  ref_tick,
  output plt_pkg::plt_state_t state,
  output logic       done_pulse
);

  plt_pkg::plt_state_t                 state_q;
  logic [plt_pkg::TUNE_CNT_W-1:0]      cnt_q;
  logic [plt_pkg::TUNE_CNT_W-1:0]      target_q;

  // ****************************************************************
  // run length counted in reference-clock ticks
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q  <= plt_pkg::PLT_IDLE;
      cnt_q    <= '0;
      target_q <= '0;
    end else begin
      unique case (state_q)
        plt_pkg::PLT_IDLE: begin
          if (start) begin
            state_q  <= plt_pkg::PLT_RUN;
            cnt_q    <= '0;
            // wait length latched so a mid-run change is harmless
            target_q <= full_wait ? FULL_CYCLES[plt_pkg::TUNE_CNT_W-1:0]
                                  : HALF_CYCLES[plt_pkg::TUNE_CNT_W-1:0]; // [RULE4]
          end
        end
        plt_pkg::PLT_RUN: begin
          if (ref_tick) begin
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q + 1'b1 == target_q) begin
              state_q <= plt_pkg::PLT_DONE; // [RULE18]
            end
          end
        end
        plt_pkg::PLT_DONE: begin
          state_q <= plt_pkg::PLT_IDLE;
        end
        // the unused code falls back to idle
        default: begin
          state_q <= plt_pkg::PLT_IDLE;
        end
      endcase
    end
  end

  assign state      = state_q;
  assign done_pulse = (state_q == plt_pkg::PLT_DONE);

  a_run_length: assert property (@(posedge sys_clk) disable iff (reset) // [RULE18]
    $rose(state_q == plt_pkg::PLT_DONE) |-> $past(ref_tick) && cnt_q == target_q)
    else $error("run ended before its tick count");

endmodule : plt_sequencer

// ===== core/plt_tuning_regs.sv
`timescale 1ns/1ps
// Operation
// [RULE1] run starts only on trigger rising edge
// [RULE2] software clears trigger after completion
// [RULE3] dual bit stores result in both slots
// [RULE4] wait bit selects full or half duration
// [RULE5] current bit doubles tuning current
// [RULE6] read-only completion flag, reset zero
// [RULE7] software loads iteration start with 110
// [RULE8] pump force picks forced current
// [RULE9] forced pump value resets 0x10
// [RULE10] testpoint selects route to pump node
// [RULE11] pump off bit stops charge pump
// [RULE12] array force applies forced array value
// [RULE13] software keeps scaling factor at 0x25
// [RULE14] loop-break bit opens the loop
// [RULE15] open loop drives dac from override
// [RULE16] applied pump current readable
// [RULE17] applied dac value readable
// [RULE18] completion after 25650 or 12825 cycles
// [RULE19] clearing trigger clears completion flag
// [RULE20] applied results kept per slot
// [RULE21] applied array setting readable
// [RULE22] read-only and reserved bits ignore writes
module plt_tuning_regs #(
  parameter int FULL_CYCLES = plt_pkg::TUNE_FULL_REF_CYCLES,
  parameter int HALF_CYCLES = plt_pkg::TUNE_HALF_REF_CYCLES
) (
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  ref_tick,
  input  plt_pkg::plt_tune_res_t     tune_res,
  input  wire logic [3:0]            tune_dac,
  output plt_pkg::plt_ana_ctrl_t     ana_ctrl
);

  // ****************************************************************
  // register state
  // ****************************************************************
  logic                 start_q;
  logic                 start_prev_q;
  logic                 dual_q;
  logic                 wait_q;
  logic                 current_q;
  logic                 complete_q;
  logic [2:0]           iter_q;
  logic                 tp1_q;
  logic                 tp2_q;
  logic                 pump_force_q;
  logic [4:0]           pump_forced_q;
  logic                 pump_off_q;
  logic                 array_force_q;
  logic [3:0]           array_forced_q;
  logic [5:0]           scaling_q;
  logic                 loop_break_q;
  logic [3:0]           dac_open_q;
  logic                 slot_q;
  plt_pkg::plt_tune_res_t res_q [2];
  logic [31:0]          prdata_q;
  logic                 pslverr_q;

  logic                 setup;
  logic                 wr_en;
  logic [7:0]           idx;
  logic [7:0]           wbyte;
  logic                 start_edge;
  plt_pkg::plt_state_t  seq_state;
  logic                 seq_done;
  plt_pkg::plt_tune_res_t res_sel;
  logic [3:0]           array_applied;
  logic [4:0]           pump_applied;
  logic [3:0]           dac_applied;

  function automatic logic idx_mapped(input logic [7:0] i);
    unique case (i)
      plt_pkg::IDX_TUNING_CONTROL, plt_pkg::IDX_APPLIED_ARRAY,
      plt_pkg::IDX_APPLIED_DAC, plt_pkg::IDX_APPLIED_PUMP,
      plt_pkg::IDX_LOOP_BREAK, plt_pkg::IDX_PUMP_SCALING,
      plt_pkg::IDX_OSC_ARRAY_FORCE, plt_pkg::IDX_PUMP_OVERRIDE,
      plt_pkg::IDX_SLOT_SELECT: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : idx_mapped

  // ****************************************************************
  // apb decode
  // ****************************************************************
  // registers hold a word each; low two address bits are ignored
  assign idx    = paddr[9:2];
  assign setup  = psel & ~penable;
  assign wr_en  = psel & penable & pwrite & idx_mapped(idx);
  assign wbyte  = pwdata[7:0];
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q & psel & penable;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pslverr_q <= 1'b0;
    end else if (setup) begin
      pslverr_q <= ~idx_mapped(idx) | (|paddr[11:10]);
    end
  end

  // ****************************************************************
  // tuning control register
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      start_q   <= 1'b0;
      dual_q    <= 1'b0;
      wait_q    <= 1'b0;
      current_q <= 1'b0;
      iter_q    <= plt_pkg::RST_ITER_START;
    end else if (wr_en && ~|paddr[11:10] && idx == plt_pkg::IDX_TUNING_CONTROL) begin
      // trigger stays where software leaves it
      start_q   <= wbyte[plt_pkg::TC_START_BIT]; // [RULE2]
      dual_q    <= wbyte[plt_pkg::TC_DUAL_BIT];
      wait_q    <= wbyte[plt_pkg::TC_WAIT_BIT];
      current_q <= wbyte[plt_pkg::TC_CURRENT_BIT];
      iter_q    <= wbyte[2:0]; // [RULE7]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      start_prev_q <= 1'b0;
    end else begin
      start_prev_q <= start_q;
    end
  end

  assign start_edge = start_q & ~start_prev_q; // [RULE1]

  // set beats the clear if both land in one cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      complete_q <= 1'b0;
    end else if (seq_done) begin
      complete_q <= 1'b1; // [RULE6]
    end else if (~start_q) begin
      complete_q <= 1'b0; // [RULE19]
    end
  end

  plt_sequencer #(
    .FULL_CYCLES (FULL_CYCLES),
    .HALF_CYCLES (HALF_CYCLES)
  ) plt_sequencer_i (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .start      (start_edge),
    .full_wait  (wait_q),
    .ref_tick   (ref_tick),
    .state      (seq_state),
    .done_pulse (seq_done)
  );

  // ****************************************************************
  // per-slot results
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      res_q[0] <= '0;
      res_q[1] <= '0;
    end else if (seq_done) begin
      if (dual_q || !slot_q) begin
        res_q[0] <= tune_res; // [RULE3]
      end
      if (dual_q || slot_q) begin
        res_q[1] <= tune_res; // [RULE3]
      end
    end
  end

  assign res_sel = res_q[slot_q]; // [RULE20]

  // ****************************************************************
  // diagnostic registers
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tp1_q         <= 1'b0;
      tp2_q         <= 1'b0;
      pump_force_q  <= 1'b0;
      pump_forced_q <= plt_pkg::RST_PUMP_FORCED; // [RULE9]
    end else if (wr_en && ~|paddr[11:10] && idx == plt_pkg::IDX_PUMP_OVERRIDE) begin
      tp1_q         <= wbyte[plt_pkg::PO_TP1_BIT]; // [RULE10]
      tp2_q         <= wbyte[plt_pkg::PO_TP2_BIT]; // [RULE10]
      pump_force_q  <= wbyte[plt_pkg::PO_FORCE_BIT];
      pump_forced_q <= wbyte[4:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pump_off_q     <= 1'b0;
      array_force_q  <= 1'b0;
      array_forced_q <= plt_pkg::RST_ARRAY_FORCED;
    end else if (wr_en && ~|paddr[11:10] && idx == plt_pkg::IDX_OSC_ARRAY_FORCE) begin
      pump_off_q     <= wbyte[plt_pkg::VO_PUMP_OFF_BIT];
      array_force_q  <= wbyte[plt_pkg::VO_FORCE_BIT];
      array_forced_q <= wbyte[3:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      scaling_q <= plt_pkg::RST_PUMP_SCALING; // [RULE13]
    end else if (wr_en && ~|paddr[11:10] && idx == plt_pkg::IDX_PUMP_SCALING) begin
      scaling_q <= wbyte[5:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      loop_break_q <= 1'b0;
      dac_open_q   <= plt_pkg::RST_DAC_OPEN;
    end else if (wr_en && ~|paddr[11:10] && idx == plt_pkg::IDX_LOOP_BREAK) begin
      loop_break_q <= wbyte[plt_pkg::LB_BREAK_BIT];
      dac_open_q   <= wbyte[3:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      slot_q <= 1'b0;
    end else if (wr_en && ~|paddr[11:10] && idx == plt_pkg::IDX_SLOT_SELECT) begin
      slot_q <= wbyte[plt_pkg::SS_SLOT_BIT];
    end
  end

  // ****************************************************************
  // applied values
  // ****************************************************************
  assign array_applied = array_force_q ? array_forced_q : res_sel.array; // [RULE12]
  assign pump_applied  = pump_force_q ? pump_forced_q : res_sel.pump; // [RULE8]
  assign dac_applied   = loop_break_q ? dac_open_q : tune_dac; // [RULE15]

  always_comb begin
    ana_ctrl                        = '0;
    ana_ctrl.tuning_run             = (seq_state == plt_pkg::PLT_RUN);
    ana_ctrl.tuning_double_current  = current_q & (seq_state == plt_pkg::PLT_RUN); // [RULE5]
    ana_ctrl.tuning_iter_start      = iter_q;
    ana_ctrl.osc_array_applied      = array_applied;
    ana_ctrl.pump_current_applied   = pump_applied;
    ana_ctrl.dac_applied            = dac_applied;
    ana_ctrl.dac_forced             = loop_break_q;
    ana_ctrl.pump_off               = pump_off_q; // [RULE11]
    ana_ctrl.loop_open              = loop_break_q; // [RULE14]
    ana_ctrl.loop_testpoint_one_sel = tp1_q;
    ana_ctrl.loop_testpoint_two_sel = tp2_q;
    ana_ctrl.pump_scaling_factor    = scaling_q;
  end

  // ****************************************************************
  // read data, captured in the setup cycle
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prdata_q <= '0;
    end else if (setup) begin
      prdata_q <= '0; // [RULE22]
      if (~|paddr[11:10]) begin
        unique case (idx)
          plt_pkg::IDX_TUNING_CONTROL: prdata_q[7:0] <= {start_q, dual_q, wait_q, current_q, complete_q, iter_q};
          plt_pkg::IDX_APPLIED_ARRAY:  prdata_q[3:0] <= array_applied; // [RULE21]
          plt_pkg::IDX_APPLIED_DAC:    prdata_q[3:0] <= dac_applied; // [RULE17]
          plt_pkg::IDX_APPLIED_PUMP:   prdata_q[4:0] <= pump_applied; // [RULE16]
          plt_pkg::IDX_LOOP_BREAK:     prdata_q[4:0] <= {loop_break_q, dac_open_q};
          plt_pkg::IDX_PUMP_SCALING:   prdata_q[5:0] <= scaling_q;
          plt_pkg::IDX_OSC_ARRAY_FORCE:   prdata_q[5:0] <= {pump_off_q, array_force_q, array_forced_q};
          plt_pkg::IDX_PUMP_OVERRIDE:  prdata_q[7:0] <= {tp1_q, tp2_q, pump_force_q, pump_forced_q};
          plt_pkg::IDX_SLOT_SELECT:    prdata_q[0]   <= slot_q;
          default:                     prdata_q      <= '0;
        endcase
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_trigger_high_held;
    start_q && start_prev_q;
  endsequence

  a_no_retrigger: assert property (@(posedge sys_clk) disable iff (reset) // [RULE1]
    s_trigger_high_held |=> seq_state != plt_pkg::PLT_RUN || $past(seq_state) == plt_pkg::PLT_RUN)
    else $error("run started without a trigger edge");

  a_edge_starts: assert property (@(posedge sys_clk) disable iff (reset) // [RULE1]
    start_edge && seq_state == plt_pkg::PLT_IDLE |=> seq_state == plt_pkg::PLT_RUN)
    else $error("trigger edge did not start a run");

  a_flag_sets: assert property (@(posedge sys_clk) disable iff (reset) // [RULE6]
    seq_done |=> complete_q)
    else $error("completion flag not set at end of run");

  a_flag_clears: assert property (@(posedge sys_clk) disable iff (reset) // [RULE19]
    !start_q && !seq_done |=> !complete_q)
    else $error("completion flag not cleared with trigger");

  a_dual_store: assert property (@(posedge sys_clk) disable iff (reset) // [RULE3]
    seq_done && dual_q |=> res_q[0] == $past(tune_res) && res_q[1] == $past(tune_res))
    else $error("dual store missed a slot");

  a_single_store: assert property (@(posedge sys_clk) disable iff (reset) // [RULE3]
    seq_done && !dual_q |=> res_q[$past(slot_q)] == $past(tune_res)
      && ($past(slot_q) ? $stable(res_q[0]) : $stable(res_q[1])))
    else $error("single store wrote the wrong slot");

  a_pump_force: assert property (@(posedge sys_clk) disable iff (reset) // [RULE8]
    pump_force_q |-> ana_ctrl.pump_current_applied == pump_forced_q)
    else $error("forced pump current not applied");

  a_array_force: assert property (@(posedge sys_clk) disable iff (reset) // [RULE12]
    !array_force_q |-> ana_ctrl.osc_array_applied == res_q[slot_q].array)
    else $error("array not following tuning result");

  a_open_dac: assert property (@(posedge sys_clk) disable iff (reset) // [RULE15]
    loop_break_q |-> ana_ctrl.loop_open && ana_ctrl.dac_applied == dac_open_q)
    else $error("open loop dac not applied");

  a_ro_write: assert property (@(posedge sys_clk) disable iff (reset) // [RULE22]
    wr_en && idx == plt_pkg::IDX_TUNING_CONTROL && !seq_done && start_q |=> complete_q == $past(complete_q))
    else $error("write changed the completion flag");

endmodule : plt_tuning_regs

// ===== testbench/pll_tuning_control_regs_tb.sv
`timescale 1ns/1ps
module pll_tuning_control_regs_tb;
  // ****************************************************************
  // clock, reset and ports
  // ****************************************************************
  localparam int FULL_N = 20;
  localparam int HALF_N = 10;
  logic                   sys_clk;
  logic                   reset;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [11:0]            paddr;
  logic [31:0]            pwdata;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   ref_tick;
  plt_pkg::plt_tune_res_t tune_res;
  logic [3:0]             tune_dac;
  plt_pkg::plt_ana_ctrl_t ana_ctrl;
  int                     err_count;
  int                     checks;
  logic [31:0]            rd;
  logic                   er;

  plt_tuning_regs #(.FULL_CYCLES(FULL_N), .HALF_CYCLES(HALF_N)) plt_tuning_regs_i (
    .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ref_tick(ref_tick), .tune_res(tune_res), .tune_dac(tune_dac), .ana_ctrl(ana_ctrl));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // one reference tick every other system cycle
  always @(posedge sys_clk) begin
    ref_tick <= reset ? 1'b0 : ~ref_tick;
  end

  // ****************************************************************
  // bus and compare tasks
  // ****************************************************************
  task stop_test;
    $display("err_count=%0d checks=%0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rdv, output logic erv);
    int n;
    n = 0;
    // start right after a rising edge, whatever the caller waited on
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h0, wd};
    @(posedge sys_clk);
    penable <= 1'b1;
    // request stands until pready is seen high at a rising edge
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 50) begin
        err_count++;
        stop_test();
      end
      @(posedge sys_clk);
    end
    rdv = prdata;
    erv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd, rd, er);
    chk({31'h0, er}, 32'h0);
  endtask : wr

  task chk_rd(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00, rd, er);
    chk(rd, {24'h0, exp});
  endtask : chk_rd

  task chk_out(input logic [7:0] got, input logic [7:0] exp);
    chk({24'h0, got}, {24'h0, exp});
  endtask : chk_out

  // starts a run and checks the flag just before and after the expected moment
  task run_tune(input logic [7:0] ctrl, input int n, input logic dbl);
    wr(plt_pkg::IDX_TUNING_CONTROL, ctrl);
    @(negedge sys_clk);
    chk_out({7'h0, ana_ctrl.tuning_run}, 8'h01);
    chk_out({7'h0, ana_ctrl.tuning_double_current}, {7'h0, dbl});
    chk_out({5'h0, ana_ctrl.tuning_iter_start}, 8'h06);
    repeat (2 * n - 8) @(posedge sys_clk);
    chk_rd(plt_pkg::IDX_TUNING_CONTROL, ctrl);
    repeat (12) @(posedge sys_clk);
    chk_rd(plt_pkg::IDX_TUNING_CONTROL, ctrl | 8'h08);
    // trigger still high: nothing may start again
    repeat (3 * n) @(posedge sys_clk);
    @(negedge sys_clk);
    chk_out({7'h0, ana_ctrl.tuning_run}, 8'h00);
    wr(plt_pkg::IDX_TUNING_CONTROL, ctrl & 8'h7f);
    chk_rd(plt_pkg::IDX_TUNING_CONTROL, ctrl & 8'h77);
  endtask : run_tune

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    err_count = 0;
    checks    = 0;
    reset     = 1'b1;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 12'h000;
    pwdata    = 32'h0;
    tune_res  = '{array: 4'ha, pump: 5'h1b};
    tune_dac  = 4'h9;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);

    chk_rd(plt_pkg::IDX_TUNING_CONTROL, 8'h05);
    chk_rd(plt_pkg::IDX_APPLIED_ARRAY, 8'h00);
    chk_rd(plt_pkg::IDX_APPLIED_PUMP, 8'h00);
    chk_rd(plt_pkg::IDX_LOOP_BREAK, 8'h04);
    chk_rd(plt_pkg::IDX_PUMP_SCALING, 8'h25);
    chk_rd(plt_pkg::IDX_OSC_ARRAY_FORCE, 8'h08);
    chk_rd(plt_pkg::IDX_PUMP_OVERRIDE, 8'h10);
    chk_rd(plt_pkg::IDX_APPLIED_DAC, 8'h09);
    chk_rd(plt_pkg::IDX_SLOT_SELECT, 8'h00);
    chk_out({2'h0, ana_ctrl.pump_scaling_factor}, 8'h25);
    $display("test reset values done");

    apb(1'b0, 8'h10, 8'h00, rd, er);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 8'h10, 8'hff, rd, er);
    chk({31'h0, er}, 32'h1);
    // reserved bits probed here: the scaling factor must stay at its reset value
    wr(plt_pkg::IDX_LOOP_BREAK, 8'hff);
    chk_rd(plt_pkg::IDX_LOOP_BREAK, 8'h1f);
    wr(plt_pkg::IDX_LOOP_BREAK, 8'h04);
    chk_rd(plt_pkg::IDX_PUMP_SCALING, 8'h25);
    wr(plt_pkg::IDX_APPLIED_PUMP, 8'h1f);
    chk_rd(plt_pkg::IDX_APPLIED_PUMP, 8'h00);
    wr(plt_pkg::IDX_TUNING_CONTROL, 8'h0e);
    chk_rd(plt_pkg::IDX_TUNING_CONTROL, 8'h06);
    $display("test unmapped and read-only done");

    run_tune(8'ha6, FULL_N, 1'b0);
    chk_rd(plt_pkg::IDX_APPLIED_ARRAY, 8'h0a);
    chk_rd(plt_pkg::IDX_APPLIED_PUMP, 8'h1b);
    wr(plt_pkg::IDX_SLOT_SELECT, 8'h01);
    chk_rd(plt_pkg::IDX_APPLIED_ARRAY, 8'h00);
    chk_rd(plt_pkg::IDX_APPLIED_PUMP, 8'h00);
    $display("test single slot full run done");

    tune_res <= '{array: 4'h5, pump: 5'h07};
    run_tune(8'hd6, HALF_N, 1'b1);
    chk_rd(plt_pkg::IDX_APPLIED_ARRAY, 8'h05);
    chk_rd(plt_pkg::IDX_APPLIED_PUMP, 8'h07);
    @(negedge sys_clk);
    chk_out({4'h0, ana_ctrl.osc_array_applied}, 8'h05);
    chk_out({3'h0, ana_ctrl.pump_current_applied}, 8'h07);
    wr(plt_pkg::IDX_SLOT_SELECT, 8'h00);
    chk_rd(plt_pkg::IDX_APPLIED_ARRAY, 8'h05);
    chk_rd(plt_pkg::IDX_APPLIED_PUMP, 8'h07);
    $display("test dual slot half run done");

    wr(plt_pkg::IDX_PUMP_OVERRIDE, 8'hfb);
    wr(plt_pkg::IDX_OSC_ARRAY_FORCE, 8'h33);
    wr(plt_pkg::IDX_LOOP_BREAK, 8'h1c);
    @(negedge sys_clk);
    chk_out({3'h0, ana_ctrl.pump_current_applied}, 8'h1b);
    chk_out({6'h0, ana_ctrl.loop_testpoint_one_sel, ana_ctrl.loop_testpoint_two_sel}, 8'h03);
    chk_out({4'h0, ana_ctrl.osc_array_applied}, 8'h03);
    chk_out({7'h0, ana_ctrl.pump_off}, 8'h01);
    chk_out({7'h0, ana_ctrl.loop_open}, 8'h01);
    chk_out({7'h0, ana_ctrl.dac_forced}, 8'h01);
    chk_out({4'h0, ana_ctrl.dac_applied}, 8'h0c);
    chk_rd(plt_pkg::IDX_APPLIED_PUMP, 8'h1b);
    chk_rd(plt_pkg::IDX_APPLIED_DAC, 8'h0c);
    chk_rd(plt_pkg::IDX_OSC_ARRAY_FORCE, 8'h33);
    wr(plt_pkg::IDX_PUMP_OVERRIDE, 8'h1b);
    wr(plt_pkg::IDX_OSC_ARRAY_FORCE, 8'h03);
    wr(plt_pkg::IDX_LOOP_BREAK, 8'h0c);
    @(negedge sys_clk);
    chk_out({3'h0, ana_ctrl.pump_current_applied}, 8'h07);
    chk_out({6'h0, ana_ctrl.loop_testpoint_one_sel, ana_ctrl.loop_testpoint_two_sel}, 8'h00);
    chk_out({4'h0, ana_ctrl.osc_array_applied}, 8'h05);
    chk_out({7'h0, ana_ctrl.pump_off}, 8'h00);
    chk_out({7'h0, ana_ctrl.loop_open}, 8'h00);
    chk_out({7'h0, ana_ctrl.dac_forced}, 8'h00);
    chk_out({4'h0, ana_ctrl.dac_applied}, 8'h09);
    $display("test overrides done");
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    stop_test();
  end
endmodule : pll_tuning_control_regs_tb
